// *** include/aip_pkg.sv ***
package aip_pkg;
    localparam int NUM_CH = 4;
    // Record numbers
    localparam logic [7:0] REC_GLOBAL = 8'h00;
    localparam logic [7:0] REC_CONFIG = 8'h01;
    localparam logic [7:0] REC_CH_BASE = 8'h80;
    // Byte positions inside record 00h
    localparam logic [2:0] IDX_DIAG = 3'h0;
    localparam logic [2:0] IDX_WBRK = 3'h1;
    localparam logic [2:0] IDX_LIMIT = 3'h2;
    localparam logic [2:0] IDX_SPARE3 = 3'h3;
    // Byte positions inside record 01h
    localparam logic [2:0] IDX_TEMP = 3'h0;
    localparam logic [2:0] IDX_REJ = 3'h1;
    localparam logic [2:0] IDX_SPARE6 = 3'h2;
    localparam logic [2:0] IDX_SPARE7 = 3'h3;
    // Byte positions inside channel record 80h+n
    localparam logic [2:0] IDX_FN = 3'h0;
    localparam logic [2:0] IDX_FO = 3'h1;
    localparam logic [2:0] IDX_UL_HI = 3'h2;
    localparam logic [2:0] IDX_UL_LO = 3'h3;
    localparam logic [2:0] IDX_LL_HI = 3'h4;
    localparam logic [2:0] IDX_LL_LO = 3'h5;
    // Reset values
    localparam logic [7:0] RST_DIAG = 8'h00;
    localparam logic [7:0] RST_WBRK = 8'h00;
    localparam logic [7:0] RST_LIMIT = 8'h00;
    localparam logic [7:0] RST_TEMP = 8'h00;
    localparam logic [7:0] RST_REJ = 8'h02;
    localparam logic [7:0] RST_SPARE = 8'h00;
    localparam logic [7:0] RST_FN = 8'h10;
    localparam logic [7:0] RST_FO = 8'h02;
    localparam logic [15:0] RST_UL = 16'h7FFF;
    localparam logic [15:0] RST_LL = 16'h8000;
    // Codes
    localparam logic [7:0] DIAG_OFF = 8'h00;
    localparam logic [7:0] DIAG_ON = 8'h40;
    localparam logic [7:0] FN_OFF = 8'hFF;
    localparam logic [3:0] FN_CLASS_RES = 4'h5;
    localparam logic [3:0] FN_CLASS_THC = 4'h7;
    localparam logic [3:0] CH_MASK = 4'hF;
    typedef enum logic [1:0] {
        AIP_REJ_OFF = 2'b00,
        AIP_REJ_60HZ = 2'b01,
        AIP_REJ_50HZ = 2'b10,
        AIP_REJ_RSVD = 2'b11
    } aip_rej_t;
    localparam logic [1:0] REJ_DEFAULT = AIP_REJ_50HZ;
endpackage

// *** hw/aip_limit_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module aip_limit_chk
    import aip_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic enable,
    input wire logic sample_valid,
    input wire logic [W-1:0] value,
    input wire logic [W-1:0] upper,
    input wire logic [W-1:0] lower,
    output logic over_r,
    output logic under_r
);
    wire logic above = $signed(value) > $signed(upper);
    wire logic below = $signed(value) < $signed(lower);
    wire logic check = enable & sample_valid;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            over_r <= 1'b0;
            under_r <= 1'b0;
        end else begin
            over_r <= check & above;
            under_r <= check & below;
        end
    end

    chk_limit_over: assert property (@(posedge clk_sys)
        disable iff (srst)
        (enable && sample_valid && $signed(value) > $signed(upper))
        |=> over_r)
        else $error("over-limit event missing");
    chk_limit_quiet: assert property (@(posedge clk_sys)
        disable iff (srst)
        !(enable && sample_valid) |=> !over_r && !under_r)
        else $error("limit event without enabled sample");
endmodule
`default_nettype wire

// *** hw/aip_param_record.sv ***
`timescale 1ns/1ps
`default_nettype none
module aip_param_record
    import aip_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic sys_stopped,
    input wire logic rec_wr,
    input wire logic rec_rd,
    input wire logic [7:0] rec_num,
    input wire logic [2:0] rec_idx,
    input wire logic [7:0] rec_wdata,
    output logic [7:0] rec_rdata_r,
    output logic rec_ack_r,
    output logic rec_err_r,
    input wire logic [NUM_CH-1:0] sample_valid,
    input wire logic [16*NUM_CH-1:0] sample_value,
    input wire logic [2:0] in_addr,
    output logic [7:0] in_rdata_r,
    output logic diag_irq_on,
    output logic [NUM_CH-1:0] channel_active,
    output logic [NUM_CH-1:0] wire_break_active,
    output logic [NUM_CH-1:0] limit_active,
    output logic [2*NUM_CH-1:0] mains_rej_eff,
    output logic [2*NUM_CH-1:0] temp_unit,
    output logic [8*NUM_CH-1:0] fn_code,
    output logic [8*NUM_CH-1:0] fn_option,
    output logic [NUM_CH-1:0] limit_over,
    output logic [NUM_CH-1:0] limit_under
);
    logic [7:0] diag_r;
    logic [3:0] wbrk_r;
    logic [3:0] limit_r;
    logic [7:0] temp_r;
    logic [7:0] rej_r;
    logic [7:0] fn_r [NUM_CH];
    logic [7:0] fo_r [NUM_CH];
    logic [15:0] ul_r [NUM_CH];
    logic [15:0] ll_r [NUM_CH];
    logic [15:0] sample_r [NUM_CH];
    logic [NUM_CH-1:0] thermal;

    // Access decode
    wire logic is_glob = rec_num == REC_GLOBAL;
    wire logic is_cfg = rec_num == REC_CONFIG;
    wire logic is_ch = rec_num[7:2] == REC_CH_BASE[7:2];
    wire logic [1:0] ch_sel = rec_num[1:0];
    wire logic idx_ok = (is_glob | is_cfg) ? (rec_idx <= IDX_SPARE3)
                      : (is_ch & (rec_idx <= IDX_LL_LO));
    wire logic hit = (is_glob | is_cfg | is_ch) & idx_ok;
    // Global enables change the measuring plan, so running writes bounce
    wire logic glob_lock = is_glob & ~sys_stopped;
    wire logic wr_ok = rec_wr & hit & ~glob_lock;
    wire logic wr_bad = rec_wr & ~(hit & ~glob_lock);
    wire logic wr_glob = wr_ok & is_glob;
    wire logic wr_cfg = wr_ok & is_cfg;
    wire logic wr_ch = wr_ok & is_ch;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            diag_r <= RST_DIAG;
            wbrk_r <= RST_WBRK[3:0];
            limit_r <= RST_LIMIT[3:0];
        end else if (wr_glob) begin
            if (rec_idx == IDX_DIAG) diag_r <= rec_wdata;
            if (rec_idx == IDX_WBRK) wbrk_r <= rec_wdata[3:0];
            if (rec_idx == IDX_LIMIT) limit_r <= rec_wdata[3:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            temp_r <= RST_TEMP;
            rej_r <= RST_REJ;
        end else if (wr_cfg) begin
            if (rec_idx == IDX_TEMP) temp_r <= rec_wdata;
            if (rec_idx == IDX_REJ) rej_r <= rec_wdata;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            wire logic sel = wr_ch & (ch_sel == 2'(g));
            wire logic [1:0] fld = rej_r[2*g+1:2*g];
            wire logic off = fn_r[g] == FN_OFF;
            wire logic [3:0] cls = fn_r[g][7:4];
            assign thermal[g] = ~off & ((cls == FN_CLASS_RES) |
                                        (cls == FN_CLASS_THC));

            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    fn_r[g] <= RST_FN;
                    fo_r[g] <= RST_FO;
                    ul_r[g] <= RST_UL;
                    ll_r[g] <= RST_LL;
                end else if (sel) begin
                    if (rec_idx == IDX_FN) fn_r[g] <= rec_wdata;
                    if (rec_idx == IDX_FO) fo_r[g] <= rec_wdata;
                    if (rec_idx == IDX_UL_HI) ul_r[g][15:8] <= rec_wdata;
                    if (rec_idx == IDX_UL_LO) ul_r[g][7:0] <= rec_wdata;
                    if (rec_idx == IDX_LL_HI) ll_r[g][15:8] <= rec_wdata;
                    if (rec_idx == IDX_LL_LO) ll_r[g][7:0] <= rec_wdata;
                end
            end

            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    sample_r[g] <= 16'h0000;
                end else if (sample_valid[g] & ~off) begin
                    sample_r[g] <= sample_value[16*g+15:16*g];
                end
            end

            // Off or thermal-and-off request both fall back to the default
            assign mains_rej_eff[2*g+1:2*g] =
                off ? REJ_DEFAULT :
                (thermal[g] & (fld == AIP_REJ_OFF)) ? REJ_DEFAULT :
                fld;
            assign channel_active[g] = ~off;
            assign wire_break_active[g] = wbrk_r[g] & thermal[g];
            assign limit_active[g] = limit_r[g] & ~off;
            assign temp_unit[2*g+1:2*g] = temp_r[2*g+1:2*g];
            assign fn_code[8*g+7:8*g] = fn_r[g];
            assign fn_option[8*g+7:8*g] = fo_r[g];

            aip_limit_chk #(
                .W(16)
            ) u_lim (
                .clk_sys(clk_sys),
                .srst(srst),
                .enable(limit_active[g]),
                .sample_valid(sample_valid[g]),
                .value(sample_value[16*g+15:16*g]),
                .upper(ul_r[g]),
                .lower(ll_r[g]),
                .over_r(limit_over[g]),
                .under_r(limit_under[g])
            );
        end
    endgenerate

    assign diag_irq_on = diag_r == DIAG_ON;

    // Readback mux, limits big-endian
    wire logic [7:0] glob_rd = (rec_idx == IDX_DIAG) ? diag_r
                             : (rec_idx == IDX_WBRK) ? {4'h0, wbrk_r}
                             : (rec_idx == IDX_LIMIT) ? {4'h0, limit_r}
                             : RST_SPARE;
    wire logic [7:0] cfg_rd = (rec_idx == IDX_TEMP) ? temp_r
                            : (rec_idx == IDX_REJ) ? mains_rej_eff
                            : RST_SPARE;
    wire logic [7:0] ch_rd = (rec_idx == IDX_FN) ? fn_r[ch_sel]
                           : (rec_idx == IDX_FO) ? fo_r[ch_sel]
                           : (rec_idx == IDX_UL_HI) ? ul_r[ch_sel][15:8]
                           : (rec_idx == IDX_UL_LO) ? ul_r[ch_sel][7:0]
                           : (rec_idx == IDX_LL_HI) ? ll_r[ch_sel][15:8]
                           : ll_r[ch_sel][7:0];
    wire logic [7:0] rd_mux = is_glob ? glob_rd
                            : is_cfg ? cfg_rd
                            : ch_rd;
    wire logic rd_ok = rec_rd & ~rec_wr & hit;
    wire logic rd_bad = rec_rd & ~rec_wr & ~hit;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rec_rdata_r <= 8'h00;
            rec_ack_r <= 1'b0;
            rec_err_r <= 1'b0;
        end else begin
            rec_rdata_r <= rd_ok ? rd_mux : 8'h00;
            rec_ack_r <= wr_ok | rd_ok;
            rec_err_r <= wr_bad | rd_bad;
        end
    end

    // Input area: even byte high half, odd byte low half
    wire logic [1:0] in_ch = in_addr[2:1];
    wire logic [7:0] in_byte = in_addr[0] ? sample_r[in_ch][7:0]
                                          : sample_r[in_ch][15:8];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            in_rdata_r <= 8'h00;
        end else begin
            in_rdata_r <= in_byte;
        end
    end

    chk_diag_enable: assert property (@(posedge clk_sys)
        disable iff (srst)
        (wr_glob && rec_idx == IDX_DIAG && rec_wdata == DIAG_ON)
        |=> diag_irq_on)
        else $error("diagnostic interrupt not enabled by 40h");
    chk_diag_disable: assert property (@(posedge clk_sys)
        disable iff (srst)
        (wr_glob && rec_idx == IDX_DIAG && rec_wdata == DIAG_OFF)
        |=> !diag_irq_on)
        else $error("diagnostic interrupt not disabled by 00h");
    chk_wbrk_store: assert property (@(posedge clk_sys)
        disable iff (srst)
        (wr_glob && rec_idx == IDX_WBRK)
        |=> wbrk_r == $past(rec_wdata[3:0]))
        else $error("wire-break enable not stored");
    chk_wbrk_mode: assert property (@(posedge clk_sys)
        disable iff (srst)
        (wire_break_active & ~thermal) == 4'h0)
        else $error("wire-break active on non-thermal channel");
    chk_limit_store: assert property (@(posedge clk_sys)
        disable iff (srst)
        (wr_glob && rec_idx == IDX_LIMIT)
        |=> limit_r == $past(rec_wdata[3:0]))
        else $error("limit enable not stored");
    chk_rej_floor: assert property (@(posedge clk_sys)
        disable iff (srst)
        (wr_cfg && rec_idx == IDX_REJ && rec_wdata == 8'h00 && thermal[0])
        |=> mains_rej_eff[1:0] == REJ_DEFAULT)
        else $error("thermal channel suppression turned off");
    chk_off_default: assert property (@(posedge clk_sys)
        disable iff (srst)
        (wr_ch && ch_sel == 2'h1 && rec_idx == IDX_FN && rec_wdata == FN_OFF)
        |=> !channel_active[1] && mains_rej_eff[3:2] == REJ_DEFAULT)
        else $error("deactivated channel not on default suppression");
    chk_run_refuse: assert property (@(posedge clk_sys)
        disable iff (srst)
        (rec_wr && is_glob && !sys_stopped)
        |=> rec_err_r && !rec_ack_r && $stable(diag_r))
        else $error("global record written while running");
    chk_fn_reset: assert property (@(posedge clk_sys)
        srst |=> fn_r[0] == RST_FN && fo_r[0] == RST_FO
                 && ul_r[0] == RST_UL && ll_r[0] == RST_LL)
        else $error("channel record reset value wrong");
    chk_input_word: assert property (@(posedge clk_sys)
        disable iff (srst)
        (in_addr == 3'h4) |=> in_rdata_r == $past(sample_r[2][15:8]))
        else $error("input area byte 4 not channel 2 high byte");
    chk_off_nostore: assert property (@(posedge clk_sys)
        disable iff (srst)
        (sample_valid[0] && fn_r[0] == FN_OFF) |=> $stable(sample_r[0]))
        else $error("deactivated channel stored a sample");
    chk_rej_store: assert property (@(posedge clk_sys)
        disable iff (srst)
        (wr_cfg && rec_idx == IDX_REJ) |=> rej_r == $past(rec_wdata))
        else $error("mains reject byte not stored");
    chk_resp_onehot: assert property (@(posedge clk_sys)
        disable iff (srst)
        !(rec_ack_r && rec_err_r))
        else $error("access both accepted and refused");
    chk_fo_store: assert property (@(posedge clk_sys)
        disable iff (srst)
        (wr_ch && ch_sel == 2'h2 && rec_idx == IDX_FO)
        |=> fo_r[2] == $past(rec_wdata))
        else $error("function option not stored");
    chk_ul_store: assert property (@(posedge clk_sys)
        disable iff (srst)
        (wr_ch && ch_sel == 2'h3 && rec_idx == IDX_UL_HI)
        |=> ul_r[3][15:8] == $past(rec_wdata))
        else $error("upper limit high byte not stored");
    chk_ll_store: assert property (@(posedge clk_sys)
        disable iff (srst)
        (wr_ch && ch_sel == 2'h0 && rec_idx == IDX_LL_LO)
        |=> ll_r[0][7:0] == $past(rec_wdata))
        else $error("lower limit low byte not stored");
    chk_lim_gate: assert property (@(posedge clk_sys)
        disable iff (srst)
        (wr_glob && rec_idx == IDX_LIMIT && rec_wdata[0] && channel_active[0])
        |=> limit_active[0])
        else $error("limit monitoring not switched on");
    chk_rej_offch: assert property (@(posedge clk_sys)
        disable iff (srst)
        !channel_active[3] |-> mains_rej_eff[7:6] == REJ_DEFAULT)
        else $error("deactivated channel off the default rejection");
    chk_wbrk_offch: assert property (@(posedge clk_sys)
        disable iff (srst)
        !channel_active[1] |-> !wire_break_active[1])
        else $error("wire-break active on deactivated channel");
    chk_idx_refuse: assert property (@(posedge clk_sys)
        disable iff (srst)
        (rec_rd && !rec_wr && is_ch && rec_idx > IDX_LL_LO)
        |=> rec_err_r && !rec_ack_r)
        else $error("out-of-record byte not refused");
endmodule
`default_nettype wire

// *** tb/aip_ctl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module aip_ctl_model (
    input wire logic clk_sys,
    input wire logic rec_ack_r,
    input wire logic rec_err_r,
    input wire logic [7:0] rec_rdata_r,
    output logic rec_wr,
    output logic rec_rd,
    output logic [7:0] rec_num,
    output logic [2:0] rec_idx,
    output logic [7:0] rec_wdata
);
    initial begin
        rec_wr = 1'b0;
        rec_rd = 1'b0;
        rec_num = 8'h00;
        rec_idx = 3'h0;
        rec_wdata = 8'h00;
    end
    // One byte per access, held up to the answer edge
    task automatic acc(input logic w, input logic [7:0] n,
        input logic [2:0] i, input logic [7:0] d,
        output logic a, output logic e, output logic [7:0] q);
        @(posedge clk_sys);
        rec_wr <= w;
        rec_rd <= !w;
        rec_num <= n;
        rec_idx <= i;
        rec_wdata <= d;
        @(posedge clk_sys);
        rec_wr <= 1'b0;
        rec_rd <= 1'b0;
        // Inverted so a stale byte is never mistaken for fresh data
        rec_wdata <= ~d;
        #1;
        a = rec_ack_r;
        e = rec_err_r;
        q = rec_rdata_r;
    endtask
endmodule
`default_nettype wire

// *** tb/tb_analog_input_param_record.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_analog_input_param_record;
    logic clk_sys, srst, sys_stopped, rec_wr, rec_rd, ack, err, diag_on;
    logic [7:0] rec_num, rec_wdata, rdata, in_rdata_r, rej_eff, t_unit;
    logic [2:0] rec_idx, in_addr;
    logic [3:0] sv, ch_act, wb_act, lm_act, l_over, l_under;
    logic [63:0] val;
    logic [31:0] fn, fno, fn_q, fo_q;
    logic [15:0] ul [4], ll [4], st [4];
    logic [7:0] lm;
    int checked = 0, bad_count = 0, cyc = 0;

    aip_param_record DUT (.clk_sys(clk_sys), .srst(srst),
        .sys_stopped(sys_stopped), .rec_wr(rec_wr), .rec_rd(rec_rd),
        .rec_num(rec_num), .rec_idx(rec_idx), .rec_wdata(rec_wdata),
        .rec_rdata_r(rdata), .rec_ack_r(ack), .rec_err_r(err),
        .sample_valid(sv), .sample_value(val), .in_addr(in_addr),
        .in_rdata_r(in_rdata_r), .diag_irq_on(diag_on),
        .channel_active(ch_act), .wire_break_active(wb_act),
        .limit_active(lm_act), .mains_rej_eff(rej_eff),
        .temp_unit(t_unit), .fn_code(fn_q), .fn_option(fo_q),
        .limit_over(l_over), .limit_under(l_under));
    aip_ctl_model u_ctl (.clk_sys(clk_sys), .rec_ack_r(ack),
        .rec_err_r(err), .rec_rdata_r(rdata), .rec_wr(rec_wr),
        .rec_rd(rec_rd), .rec_num(rec_num), .rec_idx(rec_idx),
        .rec_wdata(rec_wdata));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic report_and_stop();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x,
        input string m);
        checked++;
        if (g !== x) begin
            bad_count++;
            $display("BAD %0t %s: got %h exp %h", $time, m, g, x);
        end
    endtask
    task automatic xa(input logic w, input logic [7:0] n,
        input logic [2:0] i, input logic [7:0] d, input logic ok,
        input logic [7:0] q);
        logic a, e;
        logic [7:0] r;
        u_ctl.acc(w, n, i, d, a, e, r);
        chk({a, e, r}, {ok, !ok, q}, "record access");
    endtask
    function automatic logic [3:0] thermal(input logic [31:0] f);
        for (int n = 0; n < 4; n++) begin
            thermal[n] = f[8*n+4 +: 4] inside {4'h5, 4'h7};
        end
    endfunction
    function automatic logic [3:0] active(input logic [31:0] f);
        for (int n = 0; n < 4; n++) begin
            active[n] = f[8*n +: 8] != 8'hFF;
        end
    endfunction
    function automatic logic [7:0] exp_rej(input logic [7:0] s,
        input logic [31:0] f);
        logic [3:0] on, th;
        on = active(f);
        th = thermal(f);
        exp_rej = s;
        for (int n = 0; n < 4; n++) begin
            if (!on[n] || (th[n] && s[2*n +: 2] == 2'b00)) begin
                exp_rej[2*n +: 2] = 2'b10;
            end
        end
    endfunction
    task automatic samp(input logic [3:0] v, input logic [63:0] x);
        logic [3:0] eo, eu, a, on;
        on = active(fn);
        a = on & lm[3:0] & v;
        for (int n = 0; n < 4; n++) begin
            eo[n] = a[n] && $signed(x[16*n +: 16]) > $signed(ul[n]);
            eu[n] = a[n] && $signed(x[16*n +: 16]) < $signed(ll[n]);
            if (v[n] && on[n]) st[n] = x[16*n +: 16];
        end
        @(posedge clk_sys);
        sv <= v;
        val <= x;
        @(posedge clk_sys);
        sv <= 4'h0;
        val <= ~x;
        in_addr <= 3'($urandom);
        #1;
        chk({l_over, l_under}, {eo, eu}, "limit events");
        @(posedge clk_sys);
        #1;
        chk(in_rdata_r, in_addr[0] ? st[in_addr[2:1]][7:0] :
            st[in_addr[2:1]][15:8], "input word");
    endtask

    initial begin
        logic [47:0] rv;
        logic [7:0] d, cr, dg, wb, rej, tu;
        srst = 1'b1;
        sys_stopped = 1'b0;
        sv = 4'h0;
        val = 64'h0;
        in_addr = 3'h0;
        fn = 32'h10101010;
        for (int n = 0; n < 4; n++) st[n] = 16'h0000;
        void'($urandom(32'h8788));
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            d = i == 5 ? 8'h02 : 8'h00;
            xa('0, {7'h0, i[2]}, {1'b0, i[1:0]}, '0, '1, d);
        end
        rv = 48'h10027FFF8000;
        for (int i = 0; i < 24; i++) begin
            cr = 8'h80 + 8'(i / 6);
            xa('0, cr, 3'(i % 6), '0, '1, rv[47-8*(i%6) -: 8]);
        end
        xa('0, 8'h02, 3'h0, '0, '0, '0);
        xa('0, 8'h01, 3'h4, '0, '0, '0);
        xa('0, 8'h83, 3'h6, '0, '0, '0);
        xa('1, 8'h00, 3'h0, 8'h40, '0, '0);
        for (int k = 0; k < 40; k++) begin
            @(posedge clk_sys);
            sys_stopped <= 1'b1;
            dg = $urandom_range(1) ? 8'h40 : 8'($urandom);
            wb = 8'($urandom);
            lm = 8'($urandom);
            xa('1, 8'h00, 3'h0, dg, '1, '0);
            xa('1, 8'h00, 3'h1, wb, '1, '0);
            xa('1, 8'h00, 3'h2, lm, '1, '0);
            xa('1, 8'h00, 3'h3, 8'($urandom), '1, '0);
            xa('0, 8'h00, 3'h3, '0, '1, '0);
            xa('0, 8'h00, 3'h1, '0, '1, {4'h0, wb[3:0]});
            @(posedge clk_sys);
            sys_stopped <= 1'b0;
            xa('1, 8'h00, 3'h0, ~dg, '0, '0);
            for (int n = 0; n < 4; n++) begin
                cr = 8'h80 + 8'(n);
                d = 8'($urandom);
                // Force both thermal classes often; unused inputs get switched off
                case ($urandom_range(3))
                    0: d = 8'hFF;
                    1: d[7:4] = 4'h5;
                    2: d[7:4] = 4'h7;
                    default: ;
                endcase
                fn[8*n +: 8] = d;
                fno[8*n +: 8] = 8'($urandom);
                ul[n] = 16'($urandom);
                ll[n] = 16'($urandom);
                xa('1, cr, 3'h0, d, '1, '0);
                xa('1, cr, 3'h1, fno[8*n +: 8], '1, '0);
                for (int j = 0; j < 4; j++) begin
                    rv[15:0] = j < 2 ? ul[n] : ll[n];
                    d = j[0] ? rv[7:0] : rv[15:8];
                    xa('1, cr, 3'(j + 2), d, '1, '0);
                end
                xa('0, cr, 3'h4, '0, '1, ll[n][15:8]);
            end
            rej = 8'($urandom);
            tu = 8'($urandom);
            xa('1, 8'h01, 3'h1, rej, '1, '0);
            xa('1, 8'h01, 3'h0, tu, '1, '0);
            xa('0, 8'h01, 3'h1, '0, '1, exp_rej(rej, fn));
            chk(rej_eff, exp_rej(rej, fn), "suppression");
            chk(t_unit, tu, "temp unit");
            chk(diag_on, dg == 8'h40, "diag enable");
            chk(ch_act, active(fn), "active");
            chk(wb_act, wb[3:0] & thermal(fn), "wire break");
            chk(lm_act, lm[3:0] & active(fn), "limit on");
            chk(fn_q, fn, "function code");
            chk(fo_q, fno, "function option");
            repeat (3) samp(4'($urandom), {$urandom, $urandom});
            samp(4'hF, {ul[3], ul[2], ul[1], ul[0]});
        end
        // Corner: zero request with thermal, off and voltage channels
        xa('1, 8'h80, 3'h0, 8'h50, '1, '0);
        xa('1, 8'h81, 3'h0, 8'hFF, '1, '0);
        xa('1, 8'h82, 3'h0, 8'h70, '1, '0);
        xa('1, 8'h83, 3'h0, 8'h10, '1, '0);
        xa('1, 8'h01, 3'h1, 8'h00, '1, '0);
        xa('0, 8'h01, 3'h1, '0, '1, 8'h2A);
        chk(rej_eff, 8'h2A, "zero request floor");
        chk(ch_act, 4'hD, "deactivated channel");
        report_and_stop();
    end
endmodule
`default_nettype wire
